// [gls_pkg.sv]
// shared constants and types for the genlock lock status detector
package gls_pkg;
  // register offsets
  localparam logic [7:0] GLS_ADDR_MODE = 8'h00;
  localparam logic [7:0] GLS_ADDR_STATUS = 8'h01;
  localparam logic [7:0] GLS_ADDR_PUMP = 8'h13;
  // mode_control fields
  localparam int GLS_MODE_GENLOCK_BIT = 0;
  localparam int GLS_MODE_HOLDOVER_BIT = 1;
  localparam logic [7:0] GLS_MODE_RESET = 8'h01;
  // lock_status fields
  localparam int GLS_STAT_REF_BIT = 0;
  localparam int GLS_STAT_SD_BIT = 1;
  localparam int GLS_STAT_HD_BIT = 2;
  localparam int GLS_STAT_THR_LSB = 3;
  localparam int GLS_THR_W = 5;
  localparam logic [4:0] GLS_THR_RESET = 5'h04;
  // pump current code
  localparam int GLS_PUMP_W = 5;
  localparam logic [4:0] GLS_PUMP_RESET = 5'h08;
  // consecutive comparisons before a lock change is reported
  localparam int GLS_AGREE_COUNT = 3;
  localparam int GLS_PHASE_W = 16;

  typedef struct packed {
    logic hd_path_locked;
    logic sd_path_locked;
    logic ref_valid;
  } gls_status_s;

  typedef struct packed {
    logic write_en;
    logic read_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gls_reg_req_s;
endpackage

// [gls_phase_lock_det.sv]
// phase lock detector for the first loop: three-in-a-row filter
`timescale 1ns/1ps
`default_nettype none
module gls_phase_lock_det
  import gls_pkg::*;
#(
  parameter int PHASE_W = GLS_PHASE_W,
  parameter int THR_W = GLS_THR_W,
  parameter int AGREE = GLS_AGREE_COUNT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // comparison results
  input wire logic compare_valid,
  input wire logic [PHASE_W-1:0] phase_error,
  input wire logic [THR_W-1:0] threshold,
  // lock result
  output logic locked
);
  logic [1:0] agree_cnt;
  logic [1:0] next_agree_cnt;
  logic next_locked;
  logic in_window;

  // threshold is the largest allowed phase error
  assign in_window = phase_error <= PHASE_W'(threshold);

  always_comb begin
    next_agree_cnt = agree_cnt;
    next_locked = locked;
    if (compare_valid) begin
      // a comparison agreeing with the current state restarts the run
      if (in_window == locked) begin
        next_agree_cnt = 2'h0;
      end else if (agree_cnt == 2'(AGREE - 1)) begin
        next_locked = in_window;
        next_agree_cnt = 2'h0;
      end else begin
        next_agree_cnt = agree_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      agree_cnt <= 2'h0;
      locked <= 1'b0;
    end else begin
      agree_cnt <= next_agree_cnt;
      locked <= next_locked;
    end
  end
endmodule // gls_phase_lock_det
`default_nettype wire

// [gls_lock_status.sv]
// genlock status logic: lock filter, status flags and registers
// Operation
// - lock-fail low only when all three set
// - sd_path_locked when ref valid and loop one or four locked
// - hd_path_locked when loop two or three locked
// - threshold field limits phase detector error
// - unlock after three consecutive over-threshold comparisons
// - lock after three consecutive in-threshold comparisons
// - status bits: hd 2, sd 1, ref 0
// - acquiring: ref set, locks clear, flags 0/1
// - ref lost: clear ref, sd; keep hd in genlock mode
// - reference-missing flag is inverse of ref-valid
// - pump code 0..1f, default 08
`timescale 1ns/1ps
`default_nettype none
module gls_lock_status
  import gls_pkg::*;
#(
  parameter int PHASE_W = GLS_PHASE_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic reg_write_en,
  input wire logic reg_read_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // pins from analog and reference detector
  input wire logic ref_detected,
  input wire logic compare_valid,
  input wire logic [PHASE_W-1:0] phase_error,
  input wire logic pll4_locked,
  input wire logic pll2_locked,
  input wire logic pll3_locked,
  // controls to the loop
  output logic genlock_select,
  output logic holdover_select,
  output logic [GLS_PUMP_W-1:0] charge_pump_current_code,
  // status flags
  output logic ref_missing,
  output logic lock_fail
);
  gls_reg_req_s req;
  gls_status_s status;
  logic [7:0] mode_control;
  logic [7:0] next_mode_control;
  logic [GLS_THR_W-1:0] lock_threshold;
  logic [GLS_THR_W-1:0] next_lock_threshold;
  logic [GLS_PUMP_W-1:0] next_pump;
  logic [7:0] next_rdata;
  logic [1:0] next_flags;
  logic [1:0] flags;
  logic ref_meta, ref_sync;
  logic p4_meta, p4_sync;
  logic p2_meta, p2_sync;
  logic p3_meta, p3_sync;
  logic hd_hold;
  logic next_hd_hold;
  logic pll1_locked;

  assign req = '{write_en: reg_write_en, read_en: reg_read_en, addr: reg_addr, wdata: reg_wdata};

  // analog-side indications are asynchronous to mclk
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      p4_meta <= 1'b0;
      p4_sync <= 1'b0;
      p2_meta <= 1'b0;
      p2_sync <= 1'b0;
      p3_meta <= 1'b0;
      p3_sync <= 1'b0;
    end else begin
      ref_meta <= ref_detected;
      ref_sync <= ref_meta;
      p4_meta <= pll4_locked;
      p4_sync <= p4_meta;
      p2_meta <= pll2_locked;
      p2_sync <= p2_meta;
      p3_meta <= pll3_locked;
      p3_sync <= p3_meta;
    end
  end

  gls_phase_lock_det #(
    .PHASE_W(PHASE_W),
    .THR_W(GLS_THR_W),
    .AGREE(GLS_AGREE_COUNT)
  ) u_det (
    .mclk(mclk),
    .rstn(rstn),
    .compare_valid(compare_valid),
    .phase_error(phase_error),
    .threshold(lock_threshold),
    .locked(pll1_locked)
  );

  assign genlock_select = mode_control[GLS_MODE_GENLOCK_BIT];
  assign holdover_select = mode_control[GLS_MODE_HOLDOVER_BIT];

  // in genlock mode hd_path_locked cannot fall while the reference is lost
  always_comb begin
    next_hd_hold = p2_sync | p3_sync;
    if (genlock_select && !ref_sync) begin
      next_hd_hold = hd_hold | p2_sync | p3_sync;
    end
  end

  always_comb begin
    status.ref_valid = ref_sync;
    // sd path needs a valid reference, since it locks to it
    status.sd_path_locked = ref_sync & (pll1_locked | p4_sync);
    status.hd_path_locked = hd_hold;
  end

  // registered flag outputs
  always_comb begin
    next_flags = 2'h0;
    next_flags[0] = ~status.ref_valid;
    next_flags[1] = ~(status.ref_valid & status.sd_path_locked & status.hd_path_locked);
  end

  // register writes
  always_comb begin
    next_mode_control = mode_control;
    next_lock_threshold = lock_threshold;
    next_pump = charge_pump_current_code;
    if (req.write_en) begin
      if (req.addr == GLS_ADDR_MODE) begin
        next_mode_control = req.wdata;
      end else if (req.addr == GLS_ADDR_STATUS) begin
        // status bits are read only; only the threshold field stores
        next_lock_threshold = req.wdata[GLS_STAT_THR_LSB +: GLS_THR_W];
      end else if (req.addr == GLS_ADDR_PUMP) begin
        next_pump = req.wdata[GLS_PUMP_W-1:0];
      end
    end
  end

  // register reads, one cycle latency; unmapped reads as zero
  always_comb begin
    next_rdata = reg_rdata;
    if (req.read_en) begin
      if (req.addr == GLS_ADDR_MODE) begin
        next_rdata = mode_control;
      end else if (req.addr == GLS_ADDR_STATUS) begin
        next_rdata = {lock_threshold, status};
      end else if (req.addr == GLS_ADDR_PUMP) begin
        next_rdata = {3'h0, charge_pump_current_code};
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_control <= GLS_MODE_RESET;
      lock_threshold <= GLS_THR_RESET;
      charge_pump_current_code <= GLS_PUMP_RESET;
      reg_rdata <= 8'h00;
      flags <= 2'h3;
      hd_hold <= 1'b0;
    end else begin
      mode_control <= next_mode_control;
      lock_threshold <= next_lock_threshold;
      charge_pump_current_code <= next_pump;
      reg_rdata <= next_rdata;
      flags <= next_flags;
      hd_hold <= next_hd_hold;
    end
  end

  assign ref_missing = flags[0];
  assign lock_fail = flags[1];
endmodule // gls_lock_status
`default_nettype wire

// [gls_lock_status_properties.sv]
// lock status checker bound to the top module
`timescale 1ns/1ps
`default_nettype none
module gls_lock_status_chk
  import gls_pkg::*;
#(
  parameter int PHASE_W = GLS_PHASE_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic reg_write_en,
  input wire logic reg_read_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic ref_detected,
  input wire logic compare_valid,
  input wire logic [PHASE_W-1:0] phase_error,
  input wire logic pll4_locked,
  input wire logic pll2_locked,
  input wire logic pll3_locked,
  // outputs
  input wire logic genlock_select,
  input wire logic holdover_select,
  input wire logic [GLS_PUMP_W-1:0] charge_pump_current_code,
  input wire logic ref_missing,
  input wire logic lock_fail
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // four cycles covers sync flops plus flag register
  sequence s_ref_gone; !ref_detected [*4]; endsequence
  sequence s_ref_held; ref_detected [*4]; endsequence
  sequence s_stat_rd; reg_read_en && reg_addr == GLS_ADDR_STATUS; endsequence
  property p_miss_set; s_ref_gone |-> ref_missing; endproperty
  a_miss_set: assert property (p_miss_set) else $error("missing flag low");
  property p_miss_clr; s_ref_held |-> !ref_missing; endproperty
  a_miss_clr: assert property (p_miss_clr) else $error("missing flag high");
  property p_fail_ref; genlock_select && ref_missing |-> lock_fail; endproperty
  a_fail_ref: assert property (p_fail_ref) else $error("lock flag low without ref");
  property p_fail_hd; (ref_detected && !pll2_locked && !pll3_locked) [*6] |-> lock_fail; endproperty
  a_fail_hd: assert property (p_fail_hd) else $error("lock flag low without hd");
  property p_stat_ref; s_stat_rd |=> reg_rdata[0] == !ref_missing; endproperty
  a_stat_ref: assert property (p_stat_ref) else $error("status ref bit");
  property p_stat_fail; s_stat_rd ##0 genlock_select |=> lock_fail == !(&reg_rdata[2:0]); endproperty
  a_stat_fail: assert property (p_stat_fail) else $error("lock flag vs status");
  property p_stat_sd; s_stat_rd |=> !(reg_rdata[1] && ref_missing); endproperty
  a_stat_sd: assert property (p_stat_sd) else $error("sd bit set without ref");
  property p_pump_rst; $rose(rstn) |-> charge_pump_current_code == GLS_PUMP_RESET; endproperty
  a_pump_rst: assert property (p_pump_rst) else $error("pump code reset");
  property p_pump_wr; reg_write_en && reg_addr == GLS_ADDR_PUMP |=> charge_pump_current_code == $past(reg_wdata[4:0]); endproperty
  a_pump_wr: assert property (p_pump_wr) else $error("pump code write");
endmodule // gls_lock_status_chk
bind gls_lock_status gls_lock_status_chk #(.PHASE_W(PHASE_W)) u_chk (.*);
`default_nettype wire

// [gls_ref_source.sv]
// reference source model: reference presence and phase comparisons
`timescale 1ns/1ps
`default_nettype none
module gls_ref_source (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bench controls
  input wire logic ref_on,
  input wire logic cmp_req,
  input wire logic [15:0] err,
  // to the block
  output logic ref_detected,
  output logic compare_valid,
  output logic [15:0] phase_error
);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ref_detected <= 1'b0;
      compare_valid <= 1'b0;
      phase_error <= 16'hffff;
    end else begin
      ref_detected <= ref_on;
      compare_valid <= cmp_req;
      // toggles between comparisons so no stale error is seen
      phase_error <= cmp_req ? err : ~phase_error;
    end
  end
endmodule // gls_ref_source
`default_nettype wire

// [test_gls_lock_status.sv]
// self-checking bench for the genlock lock status block
`timescale 1ns/1ps
`default_nettype none
module test_gls_lock_status;
  import gls_pkg::*;
  logic mclk, rstn, reg_write_en, reg_read_en, ref_detected, compare_valid, pll4_locked, pll2_locked, pll3_locked;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] phase_error, err;
  logic genlock_select, holdover_select, ref_missing, lock_fail, ref_on, cmp_req;
  logic [4:0] charge_pump_current_code;
  int bad_count, samples_checked;
  logic [15:0] err_seq [5] = '{16'h5, 16'h5, 16'h4, 16'h5, 16'h5};
  gls_lock_status DUT (.mclk, .rstn, .reg_write_en, .reg_read_en, .reg_addr, .reg_wdata, .reg_rdata,
    .ref_detected, .compare_valid, .phase_error, .pll4_locked, .pll2_locked, .pll3_locked, .genlock_select,
    .holdover_select, .charge_pump_current_code, .ref_missing, .lock_fail);
  gls_ref_source SRC (.mclk, .rstn, .ref_on, .cmp_req, .err, .ref_detected, .compare_valid, .phase_error);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_write_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_write_en = 1'b0;
    step(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_read_en = 1'b1;
    reg_addr = a;
    step(1);
    reg_read_en = 1'b0;
    chk("reg_rdata", exp, reg_rdata);
    step(1);
  endtask
  task automatic cmp(logic [15:0] e);
    cmp_req = 1'b1;
    err = e;
    step(1);
    cmp_req = 1'b0;
    step(1);
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rstn, reg_write_en, reg_read_en, ref_on, cmp_req, pll4_locked, pll2_locked, pll3_locked} = 8'h00;
    {reg_addr, reg_wdata, err} = 32'h0;
    step(12);
    rstn = 1'b1;
    step(1);
    chk("pump", 8'h08, 8'(charge_pump_current_code));
    chk("lock_fail", 8'h01, 8'(lock_fail));
    chk("genlock", 8'h01, 8'(genlock_select));
    rd(GLS_ADDR_MODE, GLS_MODE_RESET);
    rd(GLS_ADDR_STATUS, 8'h20);
    $display("test reset done");
    ref_on = 1'b1;
    step(5);
    rd(GLS_ADDR_STATUS, 8'h21);
    chk("ref_missing", 8'h00, 8'(ref_missing));
    cmp(16'h4);
    cmp(16'h4);
    pll2_locked = 1'b1;
    step(5);
    rd(GLS_ADDR_STATUS, 8'h25);
    chk("lock_fail", 8'h01, 8'(lock_fail));
    cmp(16'h4);
    step(5);
    rd(GLS_ADDR_STATUS, 8'h27);
    chk("lock_fail", 8'h00, 8'(lock_fail));
    $display("test lock done");
    // error one above threshold is a miss, a match in between restarts
    foreach (err_seq[i]) cmp(err_seq[i]);
    step(5);
    rd(GLS_ADDR_STATUS, 8'h27);
    cmp(16'h5);
    step(5);
    rd(GLS_ADDR_STATUS, 8'h25);
    pll4_locked = 1'b1;
    step(5);
    rd(GLS_ADDR_STATUS, 8'h27);
    pll2_locked = 1'b0;
    pll3_locked = 1'b1;
    step(5);
    rd(GLS_ADDR_STATUS, 8'h27);
    pll4_locked = 1'b0;
    wr(GLS_ADDR_STATUS, 8'h0f);
    repeat (3) cmp(16'h2);
    step(5);
    rd(GLS_ADDR_STATUS, 8'h0d);
    repeat (3) cmp(16'h1);
    step(5);
    rd(GLS_ADDR_STATUS, 8'h0f);
    $display("test unlock done");
    ref_on = 1'b0;
    step(4);
    pll3_locked = 1'b0;
    step(4);
    rd(GLS_ADDR_STATUS, 8'h0c);
    chk("lock_fail", 8'h01, 8'(lock_fail));
    chk("ref_missing", 8'h01, 8'(ref_missing));
    wr(GLS_ADDR_MODE, 8'h03);
    chk("holdover", 8'h01, 8'(holdover_select));
    chk("genlock", 8'h01, 8'(genlock_select));
    // outside genlock the hd bit follows the loops again
    wr(GLS_ADDR_MODE, 8'h02);
    chk("genlock", 8'h00, 8'(genlock_select));
    rd(GLS_ADDR_STATUS, 8'h08);
    wr(GLS_ADDR_PUMP, 8'h1f);
    rd(GLS_ADDR_PUMP, 8'h1f);
    wr(GLS_ADDR_PUMP, 8'h00);
    chk("pump", 8'h00, 8'(charge_pump_current_code));
    rd(8'h05, 8'h00);
    $display("test loss done");
    close_out();
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule // test_gls_lock_status
`default_nettype wire
